// file: rtl/sie_exec.sv
// system instruction executor top
`timescale 1ns/1ns
`default_nettype none
`include "sie_defines.svh"
module sie_exec
  import sie_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  input  wire sie_pkg::sie_instr_s instr_in,
  input  wire sie_pkg::sie_core_s  core_in,
  input  wire logic [9:0]        result_in,
  input  wire logic              conv_done_set_in,
  input  wire logic [3:0]        interrupt_control_reg2_in,
  input  wire logic              return_flag_in,
  input  wire logic              watchdog_expire_in,
  output logic                   pc_inc_out,
  output logic                   acc_wr_out,
  output logic [3:0]             acc_data_out,
  output logic                   b_wr_out,
  output logic [3:0]             b_data_out,
  output logic [3:0]             converter_control_reg_out,
  output logic                   compare_mode_bit_out,
  output logic [7:0]             comp_ref_out,
  output logic                   comp_ref_wr_out,
  output logic                   conv_start_out,
  output logic                   conversion_done_flag_out,
  output logic                   watchdog_expiry_flag_out,
  output logic                   watchdog_stopped_out,
  output logic [3:0]             osc_control_reg_out,
  output logic                   osc_ceramic_out,
  output logic                   ring_osc_stop_out,
  output logic                   ram_backup_out
);
  sie_state_s st;
  sie_state_s next_st;
  sie_op_e    op;
  logic       exec;
  logic       mode;
  logic       done_ie;
  logic       done_clr;
  logic       wdf_clr;
  logic       wdf_set;
  logic       done_flag;
  logic       wdf_flag;

  // ==========================================================
  // decode and flags
  sie_decode u_decode (
    .word_in (instr_in.word),
    .op_out  (op)
  );

  sie_flag #(.RST_VAL(1'b0)) u_done_flag (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .set_in   (conv_done_set_in),
    .clr_in   (done_clr),
    .flag_out (done_flag)
  );

  // expiry only counts while the watchdog runs
  assign wdf_set = watchdog_expire_in & ~st.wdt_stopped;

  sie_flag #(.RST_VAL(1'b0)) u_wdf_flag (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .set_in   (wdf_set),
    .clr_in   (wdf_clr),
    .flag_out (watchdog_expiry_flag_out)
  );
  assign wdf_flag = watchdog_expiry_flag_out;

  // ==========================================================
  // qualifiers
  assign exec    = instr_in.valid & ~st.ram_backup & ~st.skip_pend;
  assign mode    = st.conv_ctrl[`SIE_MODE_BIT];
  assign done_ie = interrupt_control_reg2_in[`SIE_DONE_IE_BIT];

  // ==========================================================
  // next state of the executor
  always_comb
  begin
    next_st            = st;
    next_st.acc_wr     = 1'b0;
    next_st.b_wr       = 1'b0;
    next_st.comp_wr    = 1'b0;
    next_st.conv_start = 1'b0;
    next_st.pc_inc     = 1'b0;
    done_clr           = 1'b0;
    wdf_clr            = 1'b0;
    if (instr_in.valid && !st.ram_backup && st.skip_pend)
    begin
      // skipped word: only the counter moves
      next_st.pc_inc     = 1'b1;
      next_st.skip_pend  = 1'b0;
      next_st.prev_enable_power_off_instr  = 1'b0;
      next_st.prev_wddis = 1'b0;
    end
    else if (exec)
    begin
      next_st.pc_inc     = 1'b1;
      next_st.prev_enable_power_off_instr  = 1'b0;
      next_st.prev_wddis = 1'b0;
      case (op)
        SIE_OP_RDPAIR:
        begin
          next_st.acc_wr = 1'b1;
          next_st.b_wr   = 1'b1;
          if (!mode)
          begin
            next_st.b_data   = result_in[9:6];
            next_st.acc_data = result_in[5:2];
          end
          else
          begin
            next_st.b_data   = result_in[7:4];
            next_st.acc_data = result_in[3:0];
          end
        end
        SIE_OP_RDLOW:
        begin
          next_st.acc_wr   = 1'b1;
          next_st.acc_data = {result_in[1:0], core_in.acc[1:0]};
        end
        SIE_OP_WRREF:
        begin
          if (mode)
          begin
            next_st.comp_ref = {core_in.b, core_in.acc};
            next_st.comp_wr  = 1'b1;
          end
        end
        SIE_OP_RDCONV:
        begin
          next_st.acc_wr   = 1'b1;
          next_st.acc_data = st.conv_ctrl;
        end
        SIE_OP_WRCONV:
          next_st.conv_ctrl = core_in.acc;
        SIE_OP_START:
        begin
          done_clr           = 1'b1;
          next_st.conv_start = 1'b1;
        end
        SIE_OP_SNZDONE:
        begin
          if (!done_ie && done_flag)
          begin
            next_st.skip_pend = 1'b1;
            done_clr          = 1'b1;
          end
        end
        SIE_OP_POFF:
        begin
          if (st.prev_enable_power_off_instr)
            next_st.ram_backup = 1'b1;
        end
        SIE_OP_EPOFF:
          next_st.prev_enable_power_off_instr = 1'b1;
        SIE_OP_SNZRET:
          next_st.skip_pend = return_flag_in;
        SIE_OP_WDDIS:
          next_st.prev_wddis = 1'b1;
        SIE_OP_WDSVC:
        begin
          if (wdf_flag)
          begin
            next_st.skip_pend = 1'b1;
            wdf_clr           = 1'b1;
          end
          if (st.prev_wddis)
            next_st.wdt_stopped = 1'b1;
        end
        SIE_OP_CERSEL:
        begin
          next_st.osc_ceramic = 1'b1;
          next_st.ring_stop   = 1'b1;
        end
        SIE_OP_RCSEL:
        begin
          next_st.osc_ceramic = 1'b0;
          next_st.ring_stop   = 1'b1;
        end
        SIE_OP_RDOSC:
        begin
          next_st.acc_wr   = 1'b1;
          next_st.acc_data = st.osc_ctrl;
        end
        SIE_OP_WROSC:
          next_st.osc_ctrl = core_in.acc;
        default:
          next_st.skip_pend = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      st <= '0;
    else
      st <= next_st;
  end

  // ==========================================================
  // outputs straight from state
  assign pc_inc_out                = st.pc_inc;
  assign acc_wr_out                = st.acc_wr;
  assign acc_data_out              = st.acc_data;
  assign b_wr_out                  = st.b_wr;
  assign b_data_out                = st.b_data;
  assign converter_control_reg_out = st.conv_ctrl;
  assign compare_mode_bit_out      = st.conv_ctrl[`SIE_MODE_BIT];
  assign comp_ref_out              = st.comp_ref;
  assign comp_ref_wr_out           = st.comp_wr;
  assign conv_start_out            = st.conv_start;
  assign conversion_done_flag_out  = done_flag;
  assign watchdog_stopped_out      = st.wdt_stopped;
  assign osc_control_reg_out       = st.osc_ctrl;
  assign osc_ceramic_out           = st.osc_ceramic;
  assign ring_osc_stop_out         = st.ring_stop;
  assign ram_backup_out            = st.ram_backup;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_do(sie_op_e o);
    exec && op == o;
  endsequence
  sequence s_next_word;
    instr_in.valid [*1];
  endsequence

  property p_pair_conv;
    s_do(SIE_OP_RDPAIR) and !mode |=> acc_wr_out && b_wr_out
      && b_data_out == $past(result_in[9:6]) && acc_data_out == $past(result_in[5:2]);
  endproperty
  a_pair_conv: assert property (p_pair_conv) else $error("pair read conversion");

  property p_pair_cmp;
    s_do(SIE_OP_RDPAIR) and mode |=>
      b_data_out == $past(result_in[7:4]) && acc_data_out == $past(result_in[3:0]);
  endproperty
  a_pair_cmp: assert property (p_pair_cmp) else $error("pair read comparator");

  property p_low;
    s_do(SIE_OP_RDLOW) |=> acc_wr_out && !b_wr_out
      && acc_data_out[3:2] == $past(result_in[1:0]);
  endproperty
  a_low: assert property (p_low) else $error("low read wrong");

  property p_ref_nop;
    s_do(SIE_OP_WRREF) and !mode |=> !comp_ref_wr_out && $stable(comp_ref_out) && pc_inc_out;
  endproperty
  a_ref_nop: assert property (p_ref_nop) else $error("ref write in conversion");

  property p_ref_wr;
    s_do(SIE_OP_WRREF) and mode |=> comp_ref_wr_out
      && comp_ref_out == {$past(core_in.b), $past(core_in.acc)};
  endproperty
  a_ref_wr: assert property (p_ref_wr) else $error("ref write wrong");

  property p_wrconv_rd;
    s_do(SIE_OP_WRCONV) ##1 s_do(SIE_OP_RDCONV) |=>
      acc_data_out == $past(core_in.acc, 2) && $stable(converter_control_reg_out);
  endproperty
  a_wrconv_rd: assert property (p_wrconv_rd) else $error("control reg path");

  property p_start;
    s_do(SIE_OP_START) and !conv_done_set_in |=> conv_start_out && !conversion_done_flag_out;
  endproperty
  a_start: assert property (p_start) else $error("start failed");

  property p_snz_skip;
    s_do(SIE_OP_SNZDONE) and !done_ie and done_flag ##1 s_next_word |=>
      pc_inc_out && !acc_wr_out && !b_wr_out && !conv_start_out;
  endproperty
  a_snz_skip: assert property (p_snz_skip) else $error("skip not taken");

  property p_snz_off;
    s_do(SIE_OP_SNZDONE) and done_ie and !conv_done_set_in |=>
      !st.skip_pend && $stable(conversion_done_flag_out);
  endproperty
  a_snz_off: assert property (p_snz_off) else $error("masked test acted");

  property p_poff;
    s_do(SIE_OP_POFF) and !st.prev_enable_power_off_instr and !st.ram_backup |=> !ram_backup_out;
  endproperty
  a_poff: assert property (p_poff) else $error("power off without enable");

  property p_poff_ok;
    s_do(SIE_OP_EPOFF) ##1 s_do(SIE_OP_POFF) |=> ram_backup_out ##1 ram_backup_out;
  endproperty
  a_poff_ok: assert property (p_poff_ok) else $error("power off missed");

  property p_wdt_stop;
    s_do(SIE_OP_WDDIS) ##1 s_do(SIE_OP_WDSVC) |=> watchdog_stopped_out;
  endproperty
  a_wdt_stop: assert property (p_wdt_stop) else $error("watchdog not stopped");
endmodule : sie_exec
`default_nettype wire

// file: rtl/sie_defines.svh
// constants for the system instruction executor
// Function
// - conversion mode: pair-read puts result 9..6 in b, 5..2 in accumulator
// - comparator mode: pair-read puts result 7..4 in b, 3..0 in accumulator
// - control register bit 3 picks mode: 0 conversion, 1 comparator
// - low-read puts result bits 1,0 into accumulator bits 3,2
// - pair-to-comparator in conversion mode only advances the program counter
// - pair-to-comparator in comparator mode writes b to ref 7..4, acc to 3..0
// - control read copies converter control register into accumulator
// - control write copies accumulator into converter control register
// - start clears done flag and starts conversion or comparison per mode
// - done-test with enable bit zero skips on done flag, then clears it
// - done-test with enable bit one is a no-operation
// - no-operation advances program counter, changes nothing else
// - power-off enters ram back-up only right after the enabling instruction
// - enabling instruction validates only the immediately following power-off
// - return-flag test skips when flag is one, flag unchanged
// - watchdog service skips when expiry flag is one, then clears it
// - watchdog stops for good when service follows disable immediately
// - ceramic select picks ceramic oscillator and stops ring oscillator
// - rc select picks rc oscillator and stops ring oscillator
// - clock control register read into and written from accumulator
// - instruction word is 10 bits, upper 6 and lower 4 index the map
`ifndef SIE_DEFINES_SVH
`define SIE_DEFINES_SVH
// ==========================================================
// word layout
`define SIE_WORD_W      10
`define SIE_HI_MSB      9
`define SIE_HI_LSB      4
`define SIE_LO_MSB      3
`define SIE_LO_LSB      0
// ==========================================================
// field positions
`define SIE_MODE_BIT    3
`define SIE_DONE_IE_BIT 2
// ==========================================================
// reset values
`define SIE_NIB_RST     4'h0
`define SIE_REF_RST     8'h00
// ==========================================================
// opcodes, {upper 6, lower 4}
`define SIE_OPC_NOP     10'h000
`define SIE_OPC_POFF    10'h008
`define SIE_OPC_SNZRET  10'h003
`define SIE_OPC_EPOFF   10'h05b
`define SIE_OPC_WDDIS   10'h29c
`define SIE_OPC_WDSVC   10'h2a0
`define SIE_OPC_CERSEL  10'h29a
`define SIE_OPC_RCSEL   10'h29b
`define SIE_OPC_RDOSC   10'h252
`define SIE_OPC_WROSC   10'h216
`define SIE_OPC_RDCONV  10'h244
`define SIE_OPC_WRCONV  10'h204
`define SIE_OPC_SNZDONE 10'h287
`define SIE_OPC_RDPAIR  10'h279
`define SIE_OPC_RDLOW   10'h24f
`define SIE_OPC_WRREF   10'h239
`define SIE_OPC_START   10'h29f
`endif

// file: rtl/sie_pkg.sv
// types of the system instruction executor
package sie_pkg;
  // ==========================================================
  // decoded operations
  typedef enum logic [4:0] {
    SIE_OP_NONE, SIE_OP_NOP, SIE_OP_POFF, SIE_OP_SNZRET, SIE_OP_EPOFF,
    SIE_OP_WDDIS, SIE_OP_WDSVC, SIE_OP_CERSEL, SIE_OP_RCSEL, SIE_OP_RDOSC,
    SIE_OP_WROSC, SIE_OP_RDCONV, SIE_OP_WRCONV, SIE_OP_SNZDONE,
    SIE_OP_RDPAIR, SIE_OP_RDLOW, SIE_OP_WRREF, SIE_OP_START
  } sie_op_e;
  // instruction strobe with word
  typedef struct packed {
    logic       valid;
    logic [9:0] word;
  } sie_instr_s;
  // core registers seen by the executor
  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] b;
  } sie_core_s;
  // sticky flag state
  typedef struct packed {
    logic flag;
  } sie_flag_s;
  // executor state
  typedef struct packed {
    logic [3:0] acc_data;
    logic       acc_wr;
    logic [3:0] b_data;
    logic       b_wr;
    logic       pc_inc;
    logic [3:0] conv_ctrl;
    logic [7:0] comp_ref;
    logic       comp_wr;
    logic       conv_start;
    logic [3:0] osc_ctrl;
    logic       osc_ceramic;
    logic       ring_stop;
    logic       skip_pend;
    logic       prev_enable_power_off_instr;
    logic       prev_wddis;
    logic       wdt_stopped;
    logic       ram_backup;
  } sie_state_s;
endpackage : sie_pkg

// file: rtl/sie_decode.sv
// opcode decoder of the system instruction executor
`timescale 1ns/1ns
`default_nettype none
`include "sie_defines.svh"
module sie_decode
  import sie_pkg::*;
(
  input  wire logic [9:0] word_in,
  output var sie_pkg::sie_op_e op_out
);
  logic [5:0] hi;
  logic [3:0] lo;
  // ==========================================================
  // index fields of the map
  assign hi = word_in[`SIE_HI_MSB:`SIE_HI_LSB];
  assign lo = word_in[`SIE_LO_MSB:`SIE_LO_LSB];
  // match the word against the handled opcodes
  always_comb
  begin
    case ({hi, lo})
      `SIE_OPC_NOP:     op_out = SIE_OP_NOP;
      `SIE_OPC_POFF:    op_out = SIE_OP_POFF;
      `SIE_OPC_SNZRET:  op_out = SIE_OP_SNZRET;
      `SIE_OPC_EPOFF:   op_out = SIE_OP_EPOFF;
      `SIE_OPC_WDDIS:   op_out = SIE_OP_WDDIS;
      `SIE_OPC_WDSVC:   op_out = SIE_OP_WDSVC;
      `SIE_OPC_CERSEL:  op_out = SIE_OP_CERSEL;
      `SIE_OPC_RCSEL:   op_out = SIE_OP_RCSEL;
      `SIE_OPC_RDOSC:   op_out = SIE_OP_RDOSC;
      `SIE_OPC_WROSC:   op_out = SIE_OP_WROSC;
      `SIE_OPC_RDCONV:  op_out = SIE_OP_RDCONV;
      `SIE_OPC_WRCONV:  op_out = SIE_OP_WRCONV;
      `SIE_OPC_SNZDONE: op_out = SIE_OP_SNZDONE;
      `SIE_OPC_RDPAIR:  op_out = SIE_OP_RDPAIR;
      `SIE_OPC_RDLOW:   op_out = SIE_OP_RDLOW;
      `SIE_OPC_WRREF:   op_out = SIE_OP_WRREF;
      `SIE_OPC_START:   op_out = SIE_OP_START;
      default:          op_out = SIE_OP_NONE;
    endcase
  end
endmodule : sie_decode
`default_nettype wire

// file: rtl/sie_flag.sv
// sticky flag, set wins over clear
`timescale 1ns/1ns
`default_nettype none
module sie_flag
  import sie_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)
(
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic set_in,
  input  wire logic clr_in,
  output var  logic flag_out
);
  sie_flag_s st;
  sie_flag_s next_st;
  // ==========================================================
  // next value: set beats a same-cycle clear
  always_comb
  begin
    next_st = st;
    if (set_in)
      next_st.flag = 1'b1;
    else if (clr_in)
      next_st.flag = 1'b0;
  end
  // state register
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      st <= '{flag: RST_VAL};
    else
      st <= next_st;
  end
  assign flag_out = st.flag;
endmodule : sie_flag
`default_nettype wire

// file: verif/sie_exec_bench.sv
// self-checking bench of the system instruction executor
`timescale 1ns/1ns
`default_nettype none
`include "sie_defines.svh"
module sie_exec_bench;
  import sie_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic       clk_in;
  logic       rst_b_in;
  sie_instr_s instr;
  sie_core_s  core;
  logic [9:0] result;
  logic       done_set;
  logic [3:0] intr2;
  logic       ret_flag;
  logic       wd_exp;
  logic       pc_inc, acc_wr, b_wr, cref_wr, start;
  logic [3:0] acc_data, b_data, conv_reg, osc_reg;
  logic       mode_bit, done_flag, wd_flag, wd_stop, ceramic, ring_stop, backup;
  logic [7:0] comp_ref;
  int         n_errors;
  int         num_checks;
  // ==========================================================
  // design under test
  sie_exec u_sie_exec
  (
    .clk_in                    (clk_in),
    .rst_b_in                  (rst_b_in),
    .instr_in                  (instr),
    .core_in                   (core),
    .result_in                 (result),
    .conv_done_set_in          (done_set),
    .interrupt_control_reg2_in (intr2),
    .return_flag_in            (ret_flag),
    .watchdog_expire_in        (wd_exp),
    .pc_inc_out                (pc_inc),
    .acc_wr_out                (acc_wr),
    .acc_data_out              (acc_data),
    .b_wr_out                  (b_wr),
    .b_data_out                (b_data),
    .converter_control_reg_out (conv_reg),
    .compare_mode_bit_out      (mode_bit),
    .comp_ref_out              (comp_ref),
    .comp_ref_wr_out           (cref_wr),
    .conv_start_out            (start),
    .conversion_done_flag_out  (done_flag),
    .watchdog_expiry_flag_out  (wd_flag),
    .watchdog_stopped_out      (wd_stop),
    .osc_control_reg_out       (osc_reg),
    .osc_ceramic_out           (ceramic),
    .ring_osc_stop_out         (ring_stop),
    .ram_backup_out            (backup)
  );
  // ==========================================================
  // clock, 4 ns period
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // pulses packed as {pc, acc_wr, b_wr, cref_wr, start}
  function automatic logic [7:0] pulses();
    return {3'h0, pc_inc, acc_wr, b_wr, cref_wr, start};
  endfunction : pulses
  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // strobe one word; its effects stand when this returns
  task automatic step(input logic [9:0] w);
    instr.valid = 1'b1;
    instr.word  = w;
    @(negedge clk_in);
  endtask : step
  task automatic idle();
    instr.valid = 1'b0;
    @(negedge clk_in);
  endtask : idle
  task automatic pulse_done();
    done_set = 1'b1;
    @(negedge clk_in);
    done_set = 1'b0;
  endtask : pulse_done
  task automatic pulse_wd();
    wd_exp = 1'b1;
    @(negedge clk_in);
    wd_exp = 1'b0;
  endtask : pulse_wd
  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // ==========================================================
  // scenarios
  task automatic t_conv_mode();
    core = '{acc: 4'h3, b: 4'h0};
    result = 10'h2d6;
    step(`SIE_OPC_WRCONV);
    chk({3'h0, mode_bit, conv_reg}, 8'h03);
    step(`SIE_OPC_RDPAIR);
    chk(pulses(), 8'h1c);
    chk({b_data, acc_data}, 8'hb5);
    step(`SIE_OPC_RDLOW);
    chk({acc_wr, b_wr, cref_wr, start, acc_data}, 8'h8b);
    step(`SIE_OPC_WRREF);
    chk(pulses(), 8'h10);
    chk(comp_ref, 8'h00);
    idle();
    pulse_done();
    chk({7'h0, done_flag}, 8'h01);
    step(`SIE_OPC_START);
    chk({pc_inc, acc_wr, b_wr, cref_wr, start, 2'h0, done_flag}, 8'h88);
  endtask : t_conv_mode
  task automatic t_cmp_mode();
    core = '{acc: 4'h8, b: 4'h0};
    step(`SIE_OPC_WRCONV);
    chk({3'h0, mode_bit, conv_reg}, 8'h18);
    core.acc = 4'h0;
    step(`SIE_OPC_RDCONV);
    chk({acc_data, conv_reg}, 8'h88);
    step(`SIE_OPC_RDPAIR);
    chk({b_data, acc_data}, 8'hd6);
    core = '{acc: 4'h5, b: 4'ha};
    step(`SIE_OPC_WRREF);
    chk(pulses(), 8'h12);
    chk(comp_ref, 8'ha5);
    step(`SIE_OPC_START);
    chk(pulses(), 8'h11);
    idle();
  endtask : t_cmp_mode
  task automatic t_done_test();
    pulse_done();
    intr2 = 4'h4;
    step(`SIE_OPC_SNZDONE);
    step(`SIE_OPC_RDCONV);
    chk({pc_inc, acc_wr, b_wr, cref_wr, start, 2'h0, done_flag}, 8'hc1);
    intr2 = 4'hb;
    step(`SIE_OPC_SNZDONE);
    chk({7'h0, done_flag}, 8'h00);
    step(`SIE_OPC_RDCONV);
    chk(pulses(), 8'h10);
    step(`SIE_OPC_SNZDONE);
    step(`SIE_OPC_RDCONV);
    chk(pulses(), 8'h18);
    step(`SIE_OPC_NOP);
    chk(pulses(), 8'h10);
    chk({conv_reg, osc_reg}, 8'h80);
    chk(comp_ref, 8'ha5);
    idle();
  endtask : t_done_test
  task automatic t_return();
    ret_flag = 1'b1;
    step(`SIE_OPC_SNZRET);
    step(`SIE_OPC_RDCONV);
    chk(pulses(), 8'h10);
    ret_flag = 1'b0;
    step(`SIE_OPC_SNZRET);
    step(`SIE_OPC_RDCONV);
    chk(pulses(), 8'h18);
    idle();
  endtask : t_return
  task automatic t_watchdog();
    pulse_wd();
    chk({7'h0, wd_flag}, 8'h01);
    step(`SIE_OPC_WDSVC);
    chk({7'h0, wd_flag}, 8'h00);
    step(`SIE_OPC_RDCONV);
    chk(pulses(), 8'h10);
    step(`SIE_OPC_WDSVC);
    step(`SIE_OPC_RDCONV);
    chk(pulses(), 8'h18);
    step(`SIE_OPC_WDDIS);
    step(`SIE_OPC_NOP);
    step(`SIE_OPC_WDSVC);
    chk({7'h0, wd_stop}, 8'h00);
    step(`SIE_OPC_WDDIS);
    step(`SIE_OPC_WDSVC);
    chk({7'h0, wd_stop}, 8'h01);
    idle();
    pulse_wd();
    chk({7'h0, wd_flag}, 8'h00);
  endtask : t_watchdog
  task automatic t_osc();
    step(`SIE_OPC_CERSEL);
    chk({6'h0, ceramic, ring_stop}, 8'h03);
    step(`SIE_OPC_RCSEL);
    chk({6'h0, ceramic, ring_stop}, 8'h01);
    core.acc = 4'h6;
    step(`SIE_OPC_WROSC);
    chk({4'h0, osc_reg}, 8'h06);
    core.acc = 4'h0;
    step(`SIE_OPC_RDOSC);
    chk({acc_wr, b_wr, cref_wr, start, acc_data}, 8'h86);
    idle();
  endtask : t_osc
  task automatic t_power_off();
    step(`SIE_OPC_POFF);
    chk({pc_inc, acc_wr, b_wr, cref_wr, start, 2'h0, backup}, 8'h80);
    step(`SIE_OPC_EPOFF);
    step(`SIE_OPC_NOP);
    step(`SIE_OPC_POFF);
    chk({7'h0, backup}, 8'h00);
    step(`SIE_OPC_EPOFF);
    step(`SIE_OPC_POFF);
    chk({7'h0, backup}, 8'h01);
    step(`SIE_OPC_NOP);
    chk(pulses(), 8'h00);
    idle();
  endtask : t_power_off
  // ==========================================================
  // watchdog against a hang, far beyond the 57 cycles used
  initial
  begin
    #20000;
    n_errors++;
    final_report();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    n_errors   = 0;
    num_checks = 0;
    rst_b_in   = 1'b0;
    instr      = '0;
    core       = '0;
    result     = 10'h000;
    done_set   = 1'b0;
    intr2      = 4'h0;
    ret_flag   = 1'b0;
    wd_exp     = 1'b0;
    repeat (5) @(negedge clk_in);
    rst_b_in = 1'b1;
    chk({conv_reg, osc_reg}, 8'h00);
    chk({pc_inc, acc_wr, b_wr, cref_wr, start, done_flag, wd_flag, backup}, 8'h00);
    t_conv_mode();
    t_cmp_mode();
    t_done_test();
    t_return();
    t_watchdog();
    t_osc();
    t_power_off();
    final_report();
  end
endmodule : sie_exec_bench
`default_nettype wire
